// *** hw/exec_cfg.svh ***
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
// Operand widths
`define EXEC_DATA_W       8
`define EXEC_ADDR_W       7
// Destination select encoding
`define EXEC_DEST_ACC     1'b0
`define EXEC_DEST_FILE    1'b1
// Nibble boundary for digit carry
`define EXEC_NIB_W        4
// Reset values
`define EXEC_BYTE_ZERO    8'h00
`define EXEC_ADDR_ZERO    7'h00
`endif

// *** hw/exec_pkg.sv ***
package exec_pkg;
  // Instruction selected by the decoder
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ROTATE_RIGHT_THROUGH_CARRY,
    OP_LITERAL_MINUS_ACCUMULATOR,
    OP_REGISTER_MINUS_ACCUMULATOR,
    OP_SLEEP
  } exec_op_t;

  // Result of the subtractor
  typedef struct packed {
    logic [7:0] diff;
    logic       carry;
    logic       digit_carry;
    logic       zero;
  } sub_result_t;

  // Status flag group
  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } alu_flags_t;
endpackage : exec_pkg

// *** hw/rotate_subtract_sleep_exec.sv ***
`timescale 1ns/1ns
`include "exec_cfg.svh"
// Operation
// [RULE1] Rotate right through carry, only carry changes
// [RULE2] Destination bit 0 accumulator, 1 file
// [RULE3] Literal minus accumulator into accumulator
// [RULE4] File minus accumulator into chosen destination
// [RULE5] Subtracts set zero on zero result
// [RULE6] Sleep clears power-down, sets time-out bits
// [RULE7] Sleep clears watchdog counter and prescaler
// [RULE8] Sleep halts oscillator and execution
module rotate_subtract_sleep_exec
  import exec_pkg::*;
(
  input  wire logic                 clk_sys,           // Instruction clock
  input  wire logic                 rst_n,             // Sync reset, low
  input  wire logic                 exec_valid,        // Instruction strobe
  input  wire exec_op_t             exec_op,           // Decoded instruction
  input  wire logic [6:0]           file_addr,         // File register address
  input  wire logic                 dest_sel,          // 0 acc, 1 file
  input  wire logic [7:0]           literal,           // 8-bit literal
  input  wire logic [7:0]           file_rdata,        // Addressed file value
  input  wire logic [7:0]           accumulator,       // Current accumulator
  input  wire alu_flags_t           flags_in,          // Current status flags
  input  wire logic                 wake_up,           // Wake event from sleep
  output logic [7:0]                acc_wdata,         // New accumulator
  output logic                      acc_we,            // Accumulator write
  output logic [6:0]                file_waddr,        // File write address
  output logic [7:0]                file_wdata,        // File write data
  output logic                      file_we,           // File write
  output alu_flags_t                flags_out,         // New status flags
  output logic                      flags_we,          // Flag group write
  output logic                      timeout_status_n,  // Time-out, low
  output logic                      power_down_status_n, // Power-down, low
  output logic                      watchdog_clear,    // Clears counter+prescaler
  output logic                      osc_enable,        // Main oscillator run
  output logic                      sleeping           // Core in sleep
);
  // ----------------------------------------
  // Execution state
  // ----------------------------------------
  typedef enum logic [0:0] {
    ST_RUN,
    ST_SLEEP
  } run_state_t;

  run_state_t  state_reg;         // Run or sleep
  run_state_t  state_next;        // Next run state
  sub_result_t sub_res;           // Subtractor output
  logic [7:0]  minuend;           // Literal or file value
  logic        accept;            // Instruction taken this cycle
  logic [7:0]  result_next;       // Result byte
  alu_flags_t  flags_next;        // Flags after this instruction
  logic        write_acc_next;    // Result to accumulator
  logic        write_file_next;   // Result to file
  logic        write_flags_next;  // Flags updated

  // ----------------------------------------
  // Subtract datapath
  // ----------------------------------------
  // Pick minuend by instruction
  always_comb begin
    if (exec_op == OP_LITERAL_MINUS_ACCUMULATOR) begin
      minuend = literal;
    end else begin
      minuend = file_rdata;
    end
  end

  sub_unit u_sub (
    .minuend    (minuend),
    .subtrahend (accumulator),
    .result     (sub_res)
  );

  // Instructions only execute while running
  assign accept = exec_valid && (state_reg == ST_RUN);

  // Sleep instruction accepted this cycle
  function automatic logic sleep_taken(input logic take, input exec_op_t op);
    return take && (op == OP_SLEEP);
  endfunction : sleep_taken

  // ----------------------------------------
  // Result and flag decode
  // ----------------------------------------
  // Per-instruction result, flags and destination
  always_comb begin
    result_next      = `EXEC_BYTE_ZERO;
    flags_next       = flags_in;
    write_acc_next   = 1'b0;
    write_file_next  = 1'b0;
    write_flags_next = 1'b0;
    case (exec_op)
      // [RULE1] Rotate through carry
      OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        result_next      = {flags_in.carry, file_rdata[7:1]};
        flags_next.carry = file_rdata[0];
        write_flags_next = 1'b1;
        // [RULE2] Destination select
        write_acc_next   = (dest_sel == `EXEC_DEST_ACC);
        write_file_next  = (dest_sel == `EXEC_DEST_FILE);
      end
      // [RULE3] Literal subtract to accumulator
      OP_LITERAL_MINUS_ACCUMULATOR: begin
        result_next                 = sub_res.diff;
        flags_next.carry            = sub_res.carry;
        flags_next.digit_carry_flag = sub_res.digit_carry;
        // [RULE5] Zero flag
        flags_next.zero             = sub_res.zero;
        write_flags_next            = 1'b1;
        write_acc_next              = 1'b1;
      end
      // [RULE4] Register subtract
      OP_REGISTER_MINUS_ACCUMULATOR: begin
        result_next                 = sub_res.diff;
        flags_next.carry            = sub_res.carry;
        flags_next.digit_carry_flag = sub_res.digit_carry;
        // [RULE5] Zero flag
        flags_next.zero             = sub_res.zero;
        write_flags_next            = 1'b1;
        // [RULE2] Destination select
        write_acc_next              = (dest_sel == `EXEC_DEST_ACC);
        write_file_next             = (dest_sel == `EXEC_DEST_FILE);
      end
      // Sleep writes no data
      default: begin
        result_next = `EXEC_BYTE_ZERO;
      end
    endcase
  end

  // ----------------------------------------
  // Write-back outputs
  // ----------------------------------------
  // Register results one cycle after acceptance
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      acc_wdata  <= `EXEC_BYTE_ZERO;
      file_wdata <= `EXEC_BYTE_ZERO;
      file_waddr <= `EXEC_ADDR_ZERO;
      acc_we     <= 1'b0;
      file_we    <= 1'b0;
      flags_we   <= 1'b0;
      flags_out  <= '0;
    end else begin
      acc_wdata  <= result_next;
      file_wdata <= result_next;
      file_waddr <= file_addr;
      acc_we     <= accept && write_acc_next;
      file_we    <= accept && write_file_next;
      flags_we   <= accept && write_flags_next;
      flags_out  <= flags_next;
    end
  end

  // ----------------------------------------
  // Sleep control
  // ----------------------------------------
  // Run/sleep transitions
  always_comb begin
    case (state_reg)
      ST_RUN: begin
        // [RULE8] Enter sleep
        if (sleep_taken(accept, exec_op)) begin
          state_next = ST_SLEEP;
        end else begin
          state_next = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (wake_up) begin
          state_next = ST_RUN;
        end else begin
          state_next = ST_SLEEP;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // [RULE8] Oscillator halt
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      osc_enable <= 1'b1;
      sleeping   <= 1'b0;
    end else begin
      osc_enable <= (state_next == ST_RUN);
      sleeping   <= (state_next == ST_SLEEP);
    end
  end

  // [RULE7] Watchdog clear pulse
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      watchdog_clear <= 1'b0;
    end else begin
      watchdog_clear <= sleep_taken(accept, exec_op);
    end
  end

  // [RULE6] Status bits on sleep
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      timeout_status_n    <= 1'b1;
      power_down_status_n <= 1'b1;
    end else if (sleep_taken(accept, exec_op)) begin
      timeout_status_n    <= 1'b1;
      power_down_status_n <= 1'b0;
    end
  end
endmodule : rotate_subtract_sleep_exec

// *** hw/sub_unit.sv ***
`timescale 1ns/1ns
`include "exec_cfg.svh"
// ----------------------------------------
// Subtractor: minuend minus accumulator
// ----------------------------------------
module sub_unit
  import exec_pkg::*;
(
  input  wire logic [7:0]  minuend,
  input  wire logic [7:0]  subtrahend,
  output sub_result_t      result
);
  // Extended differences keep the borrow
  logic [8:0] full_diff;
  logic [4:0] nib_diff;

  // Compute result and flags
  always_comb begin
    full_diff          = {1'b0, minuend} - {1'b0, subtrahend};
    nib_diff           = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
    result.diff        = full_diff[7:0];
    // No borrow means subtrahend <= minuend
    result.carry       = ~full_diff[8];
    result.digit_carry = ~nib_diff[4];
    result.zero        = (full_diff[7:0] == `EXEC_BYTE_ZERO);
  end
endmodule : sub_unit

// *** testbench/exec_properties.sv ***
`timescale 1ns/1ns
// ----------------------------
// Port checker for the executor
// ----------------------------
module exec_properties
  import exec_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       exec_valid,
  input wire exec_op_t   exec_op,
  input wire logic [6:0] file_addr,
  input wire logic       dest_sel,
  input wire logic [7:0] literal,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] accumulator,
  input wire alu_flags_t flags_in,
  input wire logic       wake_up,
  input wire logic       acc_we,
  input wire logic [7:0] acc_wdata,
  input wire logic       file_we,
  input wire logic [6:0] file_waddr,
  input wire alu_flags_t flags_out,
  input wire logic       timeout_status_n,
  input wire logic       power_down_status_n,
  input wire logic       watchdog_clear,
  input wire logic       osc_enable,
  input wire logic       sleeping
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic t; // Instruction taken
  assign t = exec_valid && !sleeping;
  // One-cycle clear pulse
  sequence s_clr;
    watchdog_clear ##1 !watchdog_clear;
  endsequence
  a_rot_carry: assert property (t && exec_op == OP_ROTATE_RIGHT_THROUGH_CARRY |=>
    flags_out.carry == $past(file_rdata[0]) && flags_out.zero == $past(flags_in.zero))
    else $error("rotate carry wrong");
  a_rot_data: assert property (t && exec_op == OP_ROTATE_RIGHT_THROUGH_CARRY && !dest_sel |=>
    acc_wdata == {$past(flags_in.carry), $past(file_rdata[7:1])}) else $error("rotate data");
  a_dest_file: assert property (t && dest_sel && exec_op == OP_REGISTER_MINUS_ACCUMULATOR |=>
    file_we && !acc_we && file_waddr == $past(file_addr)) else $error("file destination");
  a_lit_sub: assert property (t && exec_op == OP_LITERAL_MINUS_ACCUMULATOR |=>
    acc_we && acc_wdata == $past(literal) - $past(accumulator)) else $error("literal sub");
  a_reg_carry: assert property (t && exec_op == OP_REGISTER_MINUS_ACCUMULATOR |=>
    flags_out.carry == ($past(accumulator) <= $past(file_rdata)) &&
    flags_out.digit_carry_flag == ($past(accumulator[3:0]) <= $past(file_rdata[3:0])))
    else $error("register sub carry");
  a_zero_flag: assert property (t && exec_op == OP_LITERAL_MINUS_ACCUMULATOR |=>
    flags_out.zero == (acc_wdata == 8'h00)) else $error("zero flag");
  a_reg_zero: assert property (t && exec_op == OP_REGISTER_MINUS_ACCUMULATOR |=>
    flags_out.zero == ($past(file_rdata) == $past(accumulator))) else $error("register zero");
  a_sleep_status: assert property (t && exec_op == OP_SLEEP |=>
    !power_down_status_n && timeout_status_n) else $error("sleep status");
  a_watchdog_clear: assert property (t && exec_op == OP_SLEEP |=> s_clr)
    else $error("watchdog clear");
  a_osc_halt: assert property (sleeping |-> !osc_enable && !acc_we && !file_we)
    else $error("sleep not halted");
  a_sleep_hold: assert property (sleeping && !wake_up |=> sleeping)
    else $error("sleep left early");
endmodule : exec_properties

// *** testbench/rotate_subtract_sleep_exec_test.sv ***
`timescale 1ns/1ns
module rotate_subtract_sleep_exec_test import exec_pkg::*;;
  logic       clk_sys, rst_n, exec_valid, dest_sel, wake_up, acc_we, file_we, flags_we;
  logic       timeout_status_n, power_down_status_n, watchdog_clear, osc_enable, sleeping;
  exec_op_t   exec_op;
  logic [6:0] file_addr, file_waddr;
  logic [7:0] literal, file_rdata, accumulator, acc_wdata, file_wdata;
  alu_flags_t flags_in, flags_out;
  logic [31:0] seed = 32'h0000_f6c9; // Random state
  logic [13:0] exp_q[$];             // Expected results
  int          errors = 0;
  int          checks_done = 0;
  rotate_subtract_sleep_exec uut (.clk_sys, .rst_n, .exec_valid, .exec_op, .file_addr,
    .dest_sel, .literal, .file_rdata, .accumulator, .flags_in, .wake_up, .acc_wdata, .acc_we,
    .file_waddr, .file_wdata, .file_we, .flags_out, .flags_we, .timeout_status_n,
    .power_down_status_n, .watchdog_clear, .osc_enable, .sleeping);
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(string n, logic [13:0] e, logic [13:0] g);
    checks_done++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask : chk
  // Drive one instruction, note its result
  task automatic issue(exec_op_t op, logic d, logic [7:0] k, f, a, alu_flags_t fl, logic q);
    logic [7:0] m;
    logic [7:0] r;
    logic       dd;
    @(negedge clk_sys);
    exec_valid = 1;
    exec_op = op;
    dest_sel = d;
    literal = k;
    file_rdata = f;
    file_addr = f[6:0];
    accumulator = a;
    flags_in = fl;
    m = (op == OP_LITERAL_MINUS_ACCUMULATOR) ? k : f;
    dd = (op == OP_LITERAL_MINUS_ACCUMULATOR) ? 1'b0 : d;
    r = m - a;
    if (op == OP_ROTATE_RIGHT_THROUGH_CARRY)
      r = {fl.carry, f[7:1]};
    if (q && op == OP_ROTATE_RIGHT_THROUGH_CARRY)
      exp_q.push_back({!d, d, 1'b1, r, f[0], fl.digit_carry_flag, fl.zero});
    else if (q)
      exp_q.push_back({!dd, dd, 1'b1, r, a <= m, a[3:0] <= m[3:0], r == 8'h00});
  endtask : issue
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  // Result watcher: oldest note against each write
  always @(negedge clk_sys) begin
    if (rst_n && (acc_we !== 1'b0 || file_we !== 1'b0)) begin
      if (exp_q.size() == 0)
        chk("unexpected", 14'h0000, {acc_we, file_we, flags_we, acc_wdata, flags_out});
      else
        chk("result", exp_q.pop_front(),
          {acc_we, file_we, flags_we, acc_we ? acc_wdata : file_wdata, flags_out});
    end
  end
  initial begin
    logic [31:0] v, w;
    exec_op_t    ops[3] = '{OP_ROTATE_RIGHT_THROUGH_CARRY, OP_LITERAL_MINUS_ACCUMULATOR,
                            OP_REGISTER_MINUS_ACCUMULATOR};
    {rst_n, wake_up, exec_valid, dest_sel, literal, file_rdata, accumulator} = '0;
    {file_addr, flags_in} = '0;
    exec_op = OP_NONE;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1;
    chk("status", 14'h0003, {timeout_status_n, power_down_status_n});
    // Boundaries back to back
    issue(OP_LITERAL_MINUS_ACCUMULATOR, 1, 8'h05, 8'h00, 8'h05, 3'b000, 1);
    issue(OP_LITERAL_MINUS_ACCUMULATOR, 0, 8'h00, 8'h00, 8'h01, 3'b000, 1);
    issue(OP_REGISTER_MINUS_ACCUMULATOR, 1, 8'h00, 8'h10, 8'h01, 3'b011, 1);
    issue(OP_ROTATE_RIGHT_THROUGH_CARRY, 1, 8'h00, 8'hff, 8'h00, 3'b100, 1);
    for (int i = 0; i < 60; i++) begin
      v = rnd();
      w = rnd();
      issue(ops[v[31:16] % 3], v[12], v[7:0], v[23:16], w[7:0], alu_flags_t'(v[10:8]), 1);
    end
    issue(OP_NONE, 1, 8'h00, 8'h3c, 8'h01, 3'b000, 0);
    @(negedge clk_sys);
    exec_valid = 0;
    repeat (2) @(negedge clk_sys);
    $display("test subtract and rotate done");
    issue(OP_SLEEP, 0, 8'h00, 8'h00, 8'h00, 3'b000, 0);
    @(negedge clk_sys);
    chk("sleep entry", 14'h0015, {watchdog_clear, power_down_status_n, timeout_status_n,
      osc_enable, sleeping});
    issue(OP_ROTATE_RIGHT_THROUGH_CARRY, 0, 8'h00, 8'h81, 8'h00, 3'b000, 0);
    @(negedge clk_sys);
    chk("in sleep", 14'h0005, {watchdog_clear, power_down_status_n, timeout_status_n,
      osc_enable, sleeping});
    exec_valid = 0;
    wake_up = 1;
    @(negedge clk_sys);
    wake_up = 0;
    chk("wake", 14'h0002, {osc_enable, sleeping});
    issue(OP_LITERAL_MINUS_ACCUMULATOR, 0, 8'h80, 8'h00, 8'hff, 3'b111, 1);
    @(negedge clk_sys);
    exec_valid = 0;
    repeat (3) @(negedge clk_sys);
    chk("pending", 14'h0000, 14'(exp_q.size()));
    $display("test sleep done");
    // Reset after sleep brings the status bits back
    rst_n = 0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1;
    chk("reset", 14'h001c, {timeout_status_n, power_down_status_n, osc_enable, sleeping,
      acc_we});
    $display("test reset done");
    summarize();
  end
endmodule : rotate_subtract_sleep_exec_test
bind rotate_subtract_sleep_exec exec_properties u_props (.clk_sys, .rst_n, .exec_valid,
  .exec_op, .file_addr, .dest_sel, .literal, .file_rdata, .accumulator, .flags_in, .wake_up,
  .acc_we, .acc_wdata, .file_we, .file_waddr, .flags_out, .timeout_status_n,
  .power_down_status_n, .watchdog_clear, .osc_enable, .sleeping);
